// *** src/adcc_pkg.sv ***
package adcc_pkg;

    // ==========================================================
    // Widths of the programmed parameters.
    // ==========================================================
    localparam int ADCC_POS_W = 9;
    localparam int ADCC_CUR_W = 7;
    localparam int ADCC_TIM_W = 7;
    localparam int ADCC_FAST_W = 4;
    localparam int ADCC_CNT_W = 16;
    localparam int ADCC_CONV_W = 5;

    // ==========================================================
    // Register offsets on the plain register port.
    // ==========================================================
    localparam logic [7:0] ADCC_OFF_REFCUR = 8'h09;
    localparam logic [7:0] ADCC_OFF_TFAST = 8'h0E;
    localparam logic [7:0] ADCC_OFF_TONMIN = 8'h0F;
    localparam logic [7:0] ADCC_OFF_TOFFMIN = 8'h10;
    localparam logic [7:0] ADCC_OFF_CONV = 8'h12;
    localparam logic [7:0] ADCC_OFF_CTRL = 8'h18;
    localparam logic [7:0] ADCC_OFF_STATUS = 8'h19;

    // ==========================================================
    // Control register fields.
    // ==========================================================
    localparam int ADCC_CTRL_TQ_BIT = 15;
    localparam int ADCC_CTRL_OFF_TIME_SETTING_LSB = 10;
    localparam int ADCC_CTRL_OFF_TIME_SETTING_W = 5;

    // ==========================================================
    // Reset values.
    // ==========================================================
    localparam logic [6:0] ADCC_RST_REFCUR = 7'h29;
    localparam logic [7:0] ADCC_RST_TFAST = 8'h19;
    localparam logic [6:0] ADCC_RST_TONMIN = 7'h29;
    localparam logic [6:0] ADCC_RST_TOFFMIN = 7'h29;
    localparam logic [15:0] ADCC_RST_CTRL = 16'h2E88;

    // ==========================================================
    // Timing: one time unit of the programmed fields, in cycles.
    // ==========================================================
    localparam int ADCC_CLK_MHZ = 125;
    localparam int ADCC_UNIT_NS = 500;
    localparam int ADCC_UNIT_CYC = (ADCC_UNIT_NS * ADCC_CLK_MHZ + 999) / 1000;
    localparam int ADCC_SAMPLE_DIV = 512;
    localparam int ADCC_SAMPLE_W = 9;
    localparam int ADCC_BLANK_CYC = 2;

    // Programmed parameters shared by both bridges.
    typedef struct packed {
        logic [ADCC_TIM_W-1:0] off_time_setting;
        logic [ADCC_TIM_W-1:0] minimum_off_time;
        logic [ADCC_TIM_W-1:0] minimum_on_time;
        logic [ADCC_FAST_W-1:0] max_fast_decay_time;
        logic [ADCC_FAST_W-1:0] fall_step_time;
    } adcc_param_type;

    // Four switch enables of one full bridge.
    typedef struct packed {
        logic hs_a;
        logic ls_a;
        logic hs_b;
        logic ls_b;
    } adcc_bridge_type;

    typedef enum logic [2:0] {ADCC_IDLE, ADCC_ON, ADCC_FAST, ADCC_SLOW, ADCC_TAIL} adcc_state_type;

endpackage

// *** src/adcc_phase.sv ***
`timescale 1ns/1ns
module adcc_phase
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic dir,
    input wire logic step_rise,
    input wire logic step_fall,
    input wire logic zero_cross,
    input wire logic at_target,
    input wire adcc_param_type param,
    output adcc_bridge_type bridge,
    output adcc_state_type state
);

    logic [ADCC_CNT_W-1:0] timer_reg;
    logic [ADCC_CNT_W-1:0] fast_reg;
    logic [ADCC_CNT_W-1:0] fall_reg;
    logic [1:0] fast_count_reg;
    logic falling_reg;
    logic fall_fast_reg;
    logic [ADCC_CNT_W-1:0] off_time_setting_cyc;
    logic [ADCC_CNT_W-1:0] minimum_on_time_cyc;
    logic [ADCC_CNT_W-1:0] fast_max_cyc;
    logic [ADCC_CNT_W-1:0] fall_max_cyc;
    logic [ADCC_CNT_W-1:0] fast_dur;
    logic short_on;

    // Convert the programmed fields into clock cycles.
    always_comb
    begin
        if (param.off_time_setting > param.minimum_off_time)
            off_time_setting_cyc = ADCC_CNT_W'(param.off_time_setting * ADCC_UNIT_CYC);
        else
            off_time_setting_cyc = ADCC_CNT_W'(param.minimum_off_time * ADCC_UNIT_CYC);
        minimum_on_time_cyc = ADCC_CNT_W'(param.minimum_on_time * ADCC_UNIT_CYC);
        fast_max_cyc = ADCC_CNT_W'((param.max_fast_decay_time + 1) * 8 * ADCC_UNIT_CYC);
        fall_max_cyc = ADCC_CNT_W'((param.fall_step_time + 1) * 8 * ADCC_UNIT_CYC);
        fast_dur = fall_fast_reg ? fall_reg : fast_reg;
        short_on = timer_reg < minimum_on_time_cyc;
    end

    // Sequencer; a reset, stop or zero crossing brings back the reset decay state.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ADCC_IDLE;
            timer_reg <= '0;
            fall_fast_reg <= 1'b0;
            falling_reg <= 1'b0;
        end
        else if (ce)
        begin
            timer_reg <= timer_reg + 1'b1;
            case (state)
                ADCC_IDLE:
                begin
                    timer_reg <= '0;
                    if (run)
                        state <= ADCC_ON;
                end
                ADCC_ON:
                begin
                    if (step_fall)
                    begin
                        state <= ADCC_FAST;
                        fall_fast_reg <= 1'b1;
                        falling_reg <= 1'b1;
                        timer_reg <= '0;
                    end
                    else if (at_target && timer_reg >= ADCC_CNT_W'(ADCC_BLANK_CYC))
                    begin
                        timer_reg <= '0;
                        if (short_on)
                        begin
                            state <= ADCC_FAST;
                            fall_fast_reg <= falling_reg;
                        end
                        else
                        begin
                            state <= ADCC_SLOW;
                            falling_reg <= 1'b0;
                        end
                    end
                end
                ADCC_FAST:
                begin
                    if (timer_reg + 1'b1 >= fast_dur)
                    begin
                        state <= ADCC_ON;
                        timer_reg <= '0;
                    end
                end
                ADCC_SLOW:
                begin
                    if (fast_count_reg == 2'd2 && timer_reg + 1'b1 + fast_reg >= off_time_setting_cyc)
                        state <= ADCC_TAIL;
                    else if (timer_reg + 1'b1 >= off_time_setting_cyc)
                    begin
                        state <= ADCC_ON;
                        timer_reg <= '0;
                    end
                end
                ADCC_TAIL:
                begin
                    if (timer_reg + 1'b1 >= off_time_setting_cyc)
                    begin
                        state <= ADCC_ON;
                        timer_reg <= '0;
                    end
                end
                default:
                    state <= ADCC_IDLE;
            endcase
            if (!run || zero_cross)
            begin
                state <= ADCC_IDLE;
                fall_fast_reg <= 1'b0;
                falling_reg <= 1'b0;
            end
        end
    end

    // Adaptive fast decay length and count of fast decays at this target.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fast_reg <= '0;
            fast_count_reg <= '0;
        end
        else if (ce)
        begin
            if (!run || zero_cross || state == ADCC_IDLE)
            begin
                fast_reg <= fast_max_cyc >> 3;
                fast_count_reg <= '0;
            end
            else if (step_rise)
            begin
                fast_count_reg <= '0;
                if (fast_reg > (fast_max_cyc >> 3))
                    fast_reg <= fast_reg >> 1;
            end
            else if (state == ADCC_ON && at_target && short_on && !falling_reg &&
                     timer_reg >= ADCC_CNT_W'(ADCC_BLANK_CYC))
            begin
                if (fast_count_reg != 2'd2)
                    fast_count_reg <= fast_count_reg + 1'b1;
                if (fast_count_reg != 2'd0)
                    fast_reg <= (fast_reg << 1) > fast_max_cyc ? fast_max_cyc : fast_reg << 1;
            end
        end
    end

    // Falling step fast decay length, kept from one falling step to the next.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            fall_reg <= '0;
        else if (ce)
        begin
            if (!run || zero_cross || (state == ADCC_IDLE && fall_reg == '0))
                fall_reg <= fall_max_cyc >> 2;
            else if (state == ADCC_ON && at_target && short_on && falling_reg &&
                     timer_reg >= ADCC_CNT_W'(ADCC_BLANK_CYC))
                fall_reg <= (fall_reg << 1) > fall_max_cyc ? fall_max_cyc : fall_reg << 1;
        end
    end

    // Switch pattern; each half bridge has at most one switch on.
    always_comb
    begin
        bridge = '0;
        case (state)
            ADCC_ON:
                bridge = dir ? 4'b1001 : 4'b0110;
            ADCC_FAST, ADCC_TAIL:
                bridge = dir ? 4'b0110 : 4'b1001;
            ADCC_SLOW:
                bridge = 4'b0101;
            default:
                bridge = '0;
        endcase
    end

endmodule

// *** src/adcc_top.sv ***
`timescale 1ns/1ns
module adcc_top
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic bridges_enable,
    input wire logic [ADCC_POS_W-1:0] electrical_position,
    input wire logic position_step,
    input wire logic [1:0] comparator_pin,
    input wire logic converter_input_pin,
    output logic converter_ramp_start,
    output logic [ADCC_CUR_W-1:0] target_a,
    output logic [ADCC_CUR_W-1:0] target_b,
    output adcc_bridge_type bridge_a,
    output adcc_bridge_type bridge_b
);

    // ==========================================================
    // Registers.
    // ==========================================================
    logic [6:0] refcur_reg;
    logic [7:0] tfast_reg;
    logic [6:0] tonmin_reg;
    logic [6:0] toffmin_reg;
    logic [15:0] ctrl_reg;
    logic [ADCC_CONV_W-1:0] conv_reg;
    adcc_param_type param;
    adcc_state_type state_a;
    adcc_state_type state_b;
    adcc_bridge_type br_a;
    adcc_bridge_type br_b;

    // Software writes; the converter register is read only.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            refcur_reg <= ADCC_RST_REFCUR;
            tfast_reg <= ADCC_RST_TFAST;
            tonmin_reg <= ADCC_RST_TONMIN;
            toffmin_reg <= ADCC_RST_TOFFMIN;
            ctrl_reg <= ADCC_RST_CTRL;
        end
        else if (ce && reg_wr)
        begin
            case (reg_addr)
                ADCC_OFF_REFCUR: refcur_reg <= reg_wdata[6:0];
                ADCC_OFF_TFAST: tfast_reg <= reg_wdata[7:0];
                ADCC_OFF_TONMIN: tonmin_reg <= reg_wdata[6:0];
                ADCC_OFF_TOFFMIN: toffmin_reg <= reg_wdata[6:0];
                ADCC_OFF_CTRL: ctrl_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (ce)
        begin
            reg_rdata <= '0;
            if (reg_rd)
            begin
                case (reg_addr)
                    ADCC_OFF_REFCUR: reg_rdata <= {9'h000, refcur_reg};
                    ADCC_OFF_TFAST: reg_rdata <= {8'h00, tfast_reg};
                    ADCC_OFF_TONMIN: reg_rdata <= {9'h000, tonmin_reg};
                    ADCC_OFF_TOFFMIN: reg_rdata <= {9'h000, toffmin_reg};
                    ADCC_OFF_CONV: reg_rdata <= {11'h000, conv_reg};
                    ADCC_OFF_CTRL: reg_rdata <= ctrl_reg;
                    ADCC_OFF_STATUS: reg_rdata <= {10'h000, state_b, state_a};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // Shared programmed parameters; the off-time field is widened by two bits.
    always_comb
    begin
        param.off_time_setting = {ctrl_reg[ADCC_CTRL_OFF_TIME_SETTING_LSB +: ADCC_CTRL_OFF_TIME_SETTING_W], 2'b00};
        param.minimum_off_time = toffmin_reg;
        param.minimum_on_time = tonmin_reg;
        param.max_fast_decay_time = tfast_reg[3:0];
        param.fall_step_time = tfast_reg[7:4];
    end

    // ==========================================================
    // Ramp-compare converter.
    // ==========================================================
    logic [1:0] adc_sync_reg;
    logic [1:0] cmp_a_sync_reg;
    logic [1:0] cmp_b_sync_reg;
    logic [ADCC_SAMPLE_W-1:0] samp_reg;
    logic [ADCC_CONV_W-1:0] ramp_reg;
    logic conv_done_reg;

    // Pins pass two flops before any logic sees them.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            adc_sync_reg <= '0;
            cmp_a_sync_reg <= '0;
            cmp_b_sync_reg <= '0;
        end
        else if (ce)
        begin
            adc_sync_reg <= {adc_sync_reg[0], converter_input_pin};
            cmp_a_sync_reg <= {cmp_a_sync_reg[0], comparator_pin[0]};
            cmp_b_sync_reg <= {cmp_b_sync_reg[0], comparator_pin[1]};
        end
    end

    // The ramp rises from the start of each sample period; the input pin is the
    // external comparator, and its first crossing fixes the result.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            samp_reg <= '0;
            ramp_reg <= '0;
            conv_done_reg <= 1'b0;
            conv_reg <= '0;
        end
        else if (ce)
        begin
            samp_reg <= samp_reg + 1'b1;
            if (samp_reg[ADCC_SAMPLE_W-1 -: ADCC_CONV_W] != ramp_reg || conv_done_reg)
                ;
            else if (adc_sync_reg[1] == 1'b0)
                ramp_reg <= ramp_reg + 1'b1;
            else
                conv_done_reg <= 1'b1;
            if (samp_reg == ADCC_SAMPLE_W'(ADCC_SAMPLE_DIV - 1))
            begin
                conv_reg <= ramp_reg;
                ramp_reg <= '0;
                conv_done_reg <= 1'b0;
            end
        end
    end

    assign converter_ramp_start = (samp_reg == '0);

    // ==========================================================
    // Target current per phase from the electrical position.
    // ==========================================================
    logic [ADCC_CUR_W-1:0] amplitude;
    logic [ADCC_CUR_W-1:0] tgt_a_next;
    logic [ADCC_CUR_W-1:0] tgt_b_next;
    logic [6:0] ang_a;
    logic [6:0] ang_b;
    logic dir_a;
    logic dir_b;
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;
    logic zero_a;
    logic zero_b;

    // Quarter-wave sine, 0..127 scaled, simple triangular fold.
    function automatic logic [ADCC_CUR_W-1:0] adcc_scale(input logic [6:0] ang, input logic [ADCC_CUR_W-1:0] amp);
        logic [13:0] prod;
        prod = 14'(ang) * 14'(amp);
        return prod[13:7];
    endfunction

    always_comb
    begin
        amplitude = ctrl_reg[ADCC_CTRL_TQ_BIT] ? {conv_reg, 2'b00} : refcur_reg;
        ang_a = electrical_position[7] ? 7'(8'h80 - {1'b0, electrical_position[6:0]}) : electrical_position[6:0];
        ang_b = electrical_position[7] ? electrical_position[6:0] : 7'(8'h7F - {1'b0, electrical_position[6:0]});
        dir_a = ~electrical_position[8];
        dir_b = ~(electrical_position[8] ^ electrical_position[7]);
        tgt_a_next = adcc_scale(ang_a, amplitude);
        tgt_b_next = adcc_scale(ang_b, amplitude);
        // The step pulse comes with the new position, while the target still holds the old value.
        rise_a = position_step && tgt_a_next > target_a;
        fall_a = position_step && tgt_a_next < target_a;
        rise_b = position_step && tgt_b_next > target_b;
        fall_b = position_step && tgt_b_next < target_b;
        zero_a = position_step && tgt_a_next == '0;
        zero_b = position_step && tgt_b_next == '0;
    end

    // Targets follow the position one cycle later on every enabled cycle, whether or not a step is flagged.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            target_a <= '0;
            target_b <= '0;
        end
        else if (ce)
        begin
            target_a <= tgt_a_next;
            target_b <= tgt_b_next;
        end
    end

    // ==========================================================
    // Two independent bridge controllers.
    // ==========================================================
    adcc_phase u_phase_a (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .run(bridges_enable),
        .dir(dir_a),
        .step_rise(rise_a),
        .step_fall(fall_a),
        .zero_cross(zero_a),
        .at_target(cmp_a_sync_reg[1]),
        .param(param),
        .bridge(br_a),
        .state(state_a)
    );

    adcc_phase u_phase_b (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .run(bridges_enable),
        .dir(dir_b),
        .step_rise(rise_b),
        .step_fall(fall_b),
        .zero_cross(zero_b),
        .at_target(cmp_b_sync_reg[1]),
        .param(param),
        .bridge(br_b),
        .state(state_b)
    );

    assign bridge_a = br_a;
    assign bridge_b = br_b;

endmodule

// *** bench/adcc_top_props.sv ***
`timescale 1ns/1ns
module adcc_top_props
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic bridges_enable,
    input wire logic [1:0] comparator_pin,
    input wire logic converter_ramp_start,
    input wire adcc_bridge_type bridge_a,
    input wire adcc_bridge_type bridge_b
);
    // ========
    // Bridge, converter and register port checks
    // ========
    // All checks share the control clock, and reset cancels them.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Cycles since the last ramp start, so the long sample period needs no long delay.
    logic [9:0] gap_cnt_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            gap_cnt_reg <= 10'h000;
        else if (converter_ramp_start)
            gap_cnt_reg <= 10'h001;
        else if (gap_cnt_reg != 10'h000 && gap_cnt_reg != 10'h3FF)
            gap_cnt_reg <= gap_cnt_reg + 10'h001;
    end

    // Both switches of one half bridge on would short the supply.
    short_a_a: assert property (!(bridge_a.hs_a && bridge_a.ls_a) && !(bridge_a.hs_b && bridge_a.ls_b))
        else $error("bridge a half bridge shorted");
    short_b_a: assert property (!(bridge_b.hs_a && bridge_b.ls_a) && !(bridge_b.hs_b && bridge_b.ls_b))
        else $error("bridge b half bridge shorted");
    stop_off_a: assert property (!bridges_enable ##1 !bridges_enable |-> bridge_a == 4'h0 && bridge_b == 4'h0)
        else $error("bridges driven while stopped");
    start_on_a: assert property ($rose(bridges_enable) |=> bridge_a inside {4'h9, 4'h6})
        else $error("enable did not start in a diagonal on state");
    // The comparator is blanked at the start of ON, so ON lasts more than one cycle unless a falling step or zero crossing ends it.
    on_hold_a: assert property (disable iff (rst || !bridges_enable)
        $changed(bridge_a) && bridge_a inside {4'h9, 4'h6} |=> $stable(bridge_a))
        else $error("on state lasted one cycle");
    cmp_end_a: assert property ((comparator_pin[0] && bridge_a == 4'h9)[*4] |=> bridge_a != 4'h9)
        else $error("bridge a stayed on after target reached");
    cmp_end_b_a: assert property ((comparator_pin[1] && bridge_b == 4'h9)[*4] |=> bridge_b != 4'h9)
        else $error("bridge b stayed on after target reached");
    ramp_period_a: assert property (gap_cnt_reg != 10'h000 |-> converter_ramp_start == (gap_cnt_reg == 10'h200))
        else $error("converter sample period wrong");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data present without a read");

    // Main scenarios reached.
    cov_slow: cover property (bridge_a == 4'h5);
    cov_fast: cover property ($past(bridge_a) == 4'h9 && bridge_a == 4'h6);
    cov_ramp: cover property (converter_ramp_start);
endmodule

bind adcc_top adcc_top_props u_props (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bridges_enable(bridges_enable), .comparator_pin(comparator_pin),
    .converter_ramp_start(converter_ramp_start), .bridge_a(bridge_a), .bridge_b(bridge_b));

// *** bench/adcc_phase_load.sv ***
`timescale 1ns/1ns
module adcc_phase_load
    import adcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire adcc_bridge_type bridge,
    input wire logic [ADCC_CUR_W-1:0] target,
    output logic at_target
);
    // ========
    // Winding current and sense comparator
    // ========
    logic [3:0] on_pat;
    int cur;

    // Current counts along the first ON direction, so a reversed current never trips the comparator.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            on_pat <= 4'h0;
            cur <= 0;
        end
        else if (bridge == 4'h0)
        begin
            on_pat <= 4'h0;
            cur <= 0;
        end
        else if (on_pat == 4'h0)
            on_pat <= bridge;
        else if (bridge == on_pat)
            cur <= cur + 4;
        else if (bridge == ~on_pat)
            cur <= cur - 4;
        else
            cur <= cur - cur / 16;
    end

    // The comparator is registered because the sense path has a delay of its own.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            at_target <= 1'b0;
        else
            at_target <= cur >= 4 * int'(target);
    end
endmodule

// *** bench/tb_adcc_top.sv ***
`timescale 1ns/1ns
module tb_adcc_top
    import adcc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bridges_enable = 1'b0;
    logic [8:0] electrical_position = 9'h040;
    logic position_step = 1'b0;
    logic converter_input_pin = 1'b1;
    logic [15:0] reg_rdata;
    logic converter_ramp_start;
    wire [1:0] comparator_pin;
    logic [ADCC_CUR_W-1:0] target_a, target_b;
    adcc_bridge_type bridge_a, bridge_b;
    logic [3:0] on_pat, pat;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'h99c2;
    int n, d;
    int fq [$];
    int regm [int] = '{8'h09: 16'h0029, 8'h0E: 16'h0019, 8'h0F: 16'h0029, 8'h10: 16'h0029, 8'h18: 16'h2E88, 8'h19: 0};
    int mask [int] = '{8'h09: 16'h007F, 8'h0E: 16'h00FF, 8'h0F: 16'h007F, 8'h10: 16'h007F, 8'h18: 16'hFFFF};

    adcc_top dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bridges_enable(bridges_enable),
        .electrical_position(electrical_position), .position_step(position_step), .comparator_pin(comparator_pin),
        .converter_input_pin(converter_input_pin), .converter_ramp_start(converter_ramp_start),
        .target_a(target_a), .target_b(target_b), .bridge_a(bridge_a), .bridge_b(bridge_b));
    adcc_phase_load load_a (.clk(clk), .rst(rst), .bridge(bridge_a), .target(target_a), .at_target(comparator_pin[0]));
    adcc_phase_load load_b (.clk(clk), .rst(rst), .bridge(bridge_b), .target(target_b), .at_target(comparator_pin[1]));

    // ========
    // Shared tasks
    // ========
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Writes to read-only or unmapped places leave the register model untouched.
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (mask.exists(a))
            regm[a] = int'(v) & mask[a];
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check("reg_rdata", reg_rdata, regm.exists(a) ? 16'(regm[a]) : 16'h0000);
    endtask

    // Stepping is done while stopped, so each start begins from the reset control state.
    task automatic start(input logic [8:0] pos);
        @(posedge clk);
        electrical_position <= pos;
        position_step <= 1'b1;
        @(posedge clk);
        position_step <= 1'b0;
        bridges_enable <= 1'b1;
        repeat (2) @(negedge clk);
        on_pat = bridge_a;
    endtask

    task automatic halt();
        @(posedge clk);
        bridges_enable <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Skips the given pattern, then counts how long the next one stands.
    task automatic run_len(input logic [3:0] skip, output int len, output logic [3:0] p);
        int k;
        k = 0;
        len = 0;
        while (bridge_a === skip && k < 20000)
        begin
            @(negedge clk);
            k++;
        end
        p = bridge_a;
        while (bridge_a === p && len < 20000)
        begin
            @(negedge clk);
            len++;
        end
    endtask

    // ========
    // Clock, watchdog and main sequence
    // ========
    // The clock toggles every half period of 4 ns.
    initial
    begin
        forever #4 clk = ~clk;
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            n_fail++;
            stop_test();
        end
    end

    // Registers first, then decay timing, then amplitude selection.
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (regm[a]) rd(8'(a));
        rd(8'h05);
        repeat (4)
        begin
            wr(8'h09, 16'($random(seed)));
            rd(8'h09);
        end
        wr(8'h19, 16'hFFFF);
        rd(8'h19);
        wr(8'h09, 16'h0040);
        wr(8'h0F, 16'h0000);
        wr(8'h10, 16'h0001);
        wr(8'h18, 16'h0688);
        rd(8'h18);
        start(9'h040);
        check("on_pattern", 16'(on_pat == 4'h9 || on_pat == 4'h6), 16'h0001);
        run_len(on_pat, n, pat);
        check("off_pattern", 16'(pat), 16'h0005);
        check("off_len", 16'(n), 16'(4 * ADCC_UNIT_CYC));
        halt();
        wr(8'h18, 16'h0288);
        start(9'h040);
        run_len(on_pat, n, pat);
        check("off_len", 16'(n), 16'(ADCC_UNIT_CYC));
        halt();
        pat = on_pat;
        start(9'h140);
        check("on_pattern", 16'(bridge_a), 16'(pat ^ 4'hF));
        halt();
        wr(8'h0E, 16'h0010);
        repeat (2)
        begin
            wr(8'h0F, 16'h007F);
            start(9'h040);
            d = ADCC_UNIT_CYC;
            repeat (5)
            begin
                fq.push_back(d);
                d = (2 * d > 8 * ADCC_UNIT_CYC) ? 8 * ADCC_UNIT_CYC : 2 * d;
            end
            repeat (5)
            begin
                run_len(on_pat, n, pat);
                check("fast_pattern", 16'(pat), 16'(on_pat ^ 4'hF));
                check("fast_len", 16'(n), 16'(fq.pop_front()));
            end
            wr(8'h0F, 16'h0000);
            wr(8'h10, 16'h0020);
            run_len(on_pat, n, pat);
            check("slow_len", 16'(n), 16'(24 * ADCC_UNIT_CYC));
            run_len(pat, n, pat);
            check("tail_pattern", 16'(pat), 16'(on_pat ^ 4'hF));
            check("tail_len", 16'(n), 16'(8 * ADCC_UNIT_CYC));
            halt();
            rd(8'h19);
        end
        wr(8'h09, 16'h007F);
        wr(8'h18, 16'h8288);
        repeat (1100) @(posedge clk);
        regm[8'h12] = 0;
        rd(8'h12);
        check("target_a", 16'(target_a), 16'h0000);
        check("target_b", 16'(target_b), 16'h0000);
        wr(8'h18, 16'h0288);
        repeat (4) @(negedge clk);
        check("target_set", 16'(target_a != 0 || target_b != 0), 16'h0001);
        stop_test();
    end
endmodule
